// ===== hdl/alarm_history_defs.svh
// Clock, timing figures and widths of the alarm history recorder
`ifndef ALARM_HISTORY_DEFS_SVH
`define ALARM_HISTORY_DEFS_SVH
`define CLK_KHZ 25000
`define TICK_MS 100
`define LONG_PRESS_MS 1000
`define REPEAT_WINDOW_S 3600
`define HIST_DEPTH 10
`define HIST_LAST_IDX 4'h9
`define CODE_W 12
`define TIME_DIGITS 10
`define TIME_BIN_W 32
`endif

// ===== hdl/alarm_history_pkg.sv
// Types shared by the alarm history recorder
package alarm_history_pkg;
	// Gray codes along idle -> code -> low -> mid -> high
	typedef enum logic [2:0] {
		ST_FUNC_SEL = 3'h0,
		ST_CODE = 3'h1,
		ST_TS_LOW = 3'h3,
		ST_TS_MID = 3'h2,
		ST_TS_HIGH = 3'h6
	} view_state_e;
endpackage

// ===== hdl/key_event_if.sv
// Raw keys in, decoded key events out
`timescale 1ns/100ps
interface key_event_if;
	logic key_step;
	logic key_up;
	logic key_down;
	logic step_short;
	logic step_long;
	logic up_press;
	logic down_press;
	modport detector (input key_step, input key_up, input key_down,
		output step_short, output step_long, output up_press, output down_press);
	modport user (output key_step, output key_up, output key_down,
		input step_short, input step_long, input up_press, input down_press);
endinterface

// ===== hdl/key_press_detect.sv
// Keypad press decoder: short and long press of the step key, up and down edges
`timescale 1ns/100ps
module key_press_detect #(
	parameter logic [31:0] LONG_CYCLES = 32'd25000000
) (
	input wire logic clock,
	input wire logic rstn,
	key_event_if.detector keys
);
	logic step_prev_reg;
	logic up_prev_reg;
	logic down_prev_reg;
	logic long_fired_reg;
	logic [31:0] hold_cnt_reg;
	logic step_short_reg;
	logic step_long_reg;
	logic up_press_reg;
	logic down_press_reg;

	// Previous key levels for edge detection
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			step_prev_reg <= 1'b0;
			up_prev_reg <= 1'b0;
			down_prev_reg <= 1'b0;
		end
		else
		begin
			step_prev_reg <= keys.key_step;
			up_prev_reg <= keys.key_up;
			down_prev_reg <= keys.key_down;
		end
	end

	// Hold time of the step key; saturates so a held key fires once
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			hold_cnt_reg <= 32'h0;
		else if (!keys.key_step)
			hold_cnt_reg <= 32'h0;
		else if (hold_cnt_reg != LONG_CYCLES)
			hold_cnt_reg <= hold_cnt_reg + 32'h1;
	end

	// Long fires while held; short only on a release before that
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			long_fired_reg <= 1'b0;
			step_long_reg <= 1'b0;
			step_short_reg <= 1'b0;
		end
		else
		begin
			step_long_reg <= keys.key_step && hold_cnt_reg == LONG_CYCLES - 32'h1;
			step_short_reg <= !keys.key_step && step_prev_reg && !long_fired_reg;
			if (!keys.key_step)
				long_fired_reg <= 1'b0;
			else if (hold_cnt_reg == LONG_CYCLES - 32'h1)
				long_fired_reg <= 1'b1;
		end
	end

	// Up and down act on the press edge
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			up_press_reg <= 1'b0;
			down_press_reg <= 1'b0;
		end
		else
		begin
			up_press_reg <= keys.key_up && !up_prev_reg;
			down_press_reg <= keys.key_down && !down_prev_reg;
		end
	end

	assign keys.step_short = step_short_reg;
	assign keys.step_long = step_long_reg;
	assign keys.up_press = up_press_reg;
	assign keys.down_press = down_press_reg;
endmodule // key_press_detect

// ===== hdl/alarm_history_recorder.sv
// Alarm history recorder: ten stamped alarms browsed on keypad and display
`timescale 1ns/100ps
`include "alarm_history_defs.svh"
// How it works
// - Ten newest alarms kept as code plus stamp; a new one pushes out oldest.
// - Operating time counts 100 ms steps while powered; latched on each stored alarm.
// - Time counter wide enough to run about 13 years without wrapping.
// - Display index shows age; down steps older, up steps newer.
// - Step key shows stamp as low four, middle four, then high two digits.
// - Step key after the high digits returns to the alarm code.
// - Same code repeated within one hour is not stored.
// - Empty slot is shown as a dash pattern.
// - History survives alarm reset and main power loss; only clear and rstn erase it.
// - One second step press with history view selected shows newest entry.
module alarm_history_recorder
	import alarm_history_pkg::*;
#(
	parameter logic [31:0] TICK_CYCLES = 32'(`TICK_MS * `CLK_KHZ),
	parameter logic [31:0] LONG_CYCLES = 32'(`LONG_PRESS_MS * `CLK_KHZ)
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic power_on,
	input wire logic alarm_valid,
	input wire logic [`CODE_W-1:0] alarm_code,
	input wire logic alarm_reset,
	input wire logic history_view_function,
	input wire logic history_clear_function,
	input wire logic key_step,
	input wire logic key_up,
	input wire logic key_down,
	output view_state_e disp_state,
	output logic [3:0] disp_index,
	output logic [15:0] disp_digits,
	output logic disp_empty,
	output logic view_active
);
	localparam logic [31:0] HOUR_TICKS = 32'(`REPEAT_WINDOW_S * 1000 / `TICK_MS);

	key_event_if keys ();
	logic [31:0] prescale_reg;
	logic tick;
	logic [`TIME_BIN_W-1:0] time_bin_reg;
	logic [4*`TIME_DIGITS-1:0] time_bcd_reg;
	logic [`TIME_DIGITS:0] carry;
	logic [`HIST_DEPTH-1:0] valid_reg;
	logic [`CODE_W-1:0] code_reg [0:`HIST_DEPTH-1];
	logic [4*`TIME_DIGITS-1:0] ts_bcd_reg [0:`HIST_DEPTH-1];
	logic [`TIME_BIN_W-1:0] ts_bin_reg [0:`HIST_DEPTH-1];
	logic [`HIST_DEPTH-1:0] recent_hit;
	logic store;
	view_state_e state_reg;
	logic [3:0] index_reg;
	logic [`CODE_W-1:0] sel_code;
	logic [4*`TIME_DIGITS-1:0] sel_ts;

	assign keys.key_step = key_step;
	assign keys.key_up = key_up;
	assign keys.key_down = key_down;

	key_press_detect #(.LONG_CYCLES(LONG_CYCLES)) i_key_press_detect (
		.clock(clock),
		.rstn(rstn),
		.keys(keys)
	);

	// 100 ms prescaler, frozen while power is off
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			prescale_reg <= 32'h0;
		else if (power_on)
			prescale_reg <= tick ? 32'h0 : prescale_reg + 32'h1;
	end
	assign tick = power_on && prescale_reg == TICK_CYCLES - 32'h1;

	// Binary total, used for the repeat window; 32 bits last about 13.6 years
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			time_bin_reg <= 32'h0;
		else if (tick)
			time_bin_reg <= time_bin_reg + 32'h1;
	end

	// Decimal copy of the same total so the display needs no converter
	assign carry[0] = tick;
	generate
		for (genvar d = 0; d < `TIME_DIGITS; d++)
		begin : g_digit
			assign carry[d+1] = carry[d] && time_bcd_reg[4*d +: 4] == 4'h9;
			always_ff @(posedge clock or negedge rstn)
			begin
				if (!rstn)
					time_bcd_reg[4*d +: 4] <= 4'h0;
				else if (carry[d])
					time_bcd_reg[4*d +: 4] <= (time_bcd_reg[4*d +: 4] == 4'h9) ? 4'h0 : time_bcd_reg[4*d +: 4] + 4'h1;
			end
		end
	endgenerate

	// Repeat check per slot; any hit means the newest match is inside the hour too
	generate
		for (genvar i = 0; i < `HIST_DEPTH; i++)
		begin : g_slot
			// Slot 0 has no neighbour; keep its unused source index in range
			localparam int PREV_SLOT = (i == 0) ? 0 : i - 1;
			assign recent_hit[i] = valid_reg[i] && code_reg[i] == alarm_code
				&& (time_bin_reg - ts_bin_reg[i]) <= HOUR_TICKS;
			// Slot shift: slot 0 takes the new alarm, the last slot falls off
			always_ff @(posedge clock or negedge rstn)
			begin
				if (!rstn)
				begin
					valid_reg[i] <= 1'b0;
					code_reg[i] <= '0;
					ts_bcd_reg[i] <= '0;
					ts_bin_reg[i] <= '0;
				end
				else if (history_clear_function)
					valid_reg[i] <= 1'b0;
				else if (store)
				begin
					if (i == 0)
					begin
						valid_reg[i] <= 1'b1;
						code_reg[i] <= alarm_code;
						ts_bcd_reg[i] <= time_bcd_reg;
						ts_bin_reg[i] <= time_bin_reg;
					end
					else
					begin
						valid_reg[i] <= valid_reg[PREV_SLOT];
						code_reg[i] <= code_reg[PREV_SLOT];
						ts_bcd_reg[i] <= ts_bcd_reg[PREV_SLOT];
						ts_bin_reg[i] <= ts_bin_reg[PREV_SLOT];
					end
				end
			end
		end
	endgenerate
	// Alarm reset is deliberately not an input to the history
	assign store = alarm_valid && recent_hit == '0;

	// Browse state; long press outranks short, short outranks up and down
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= ST_FUNC_SEL;
			index_reg <= 4'h0;
		end
		else
		begin
			case (state_reg)
				ST_FUNC_SEL:
					if (keys.step_long && history_view_function)
					begin
						state_reg <= ST_CODE;
						index_reg <= 4'h0;
					end
				ST_CODE, ST_TS_LOW, ST_TS_MID, ST_TS_HIGH:
					if (keys.step_long)
						state_reg <= ST_FUNC_SEL;
					else if (keys.step_short)
					begin
						case (state_reg)
							ST_CODE: state_reg <= ST_TS_LOW;
							ST_TS_LOW: state_reg <= ST_TS_MID;
							ST_TS_MID: state_reg <= ST_TS_HIGH;
							default: state_reg <= ST_CODE;
						endcase
					end
					else if (keys.down_press && index_reg != `HIST_LAST_IDX)
					begin
						index_reg <= index_reg + 4'h1;
						state_reg <= ST_CODE;
					end
					else if (keys.up_press && index_reg != 4'h0)
					begin
						index_reg <= index_reg - 4'h1;
						state_reg <= ST_CODE;
					end
				default: state_reg <= ST_FUNC_SEL;
			endcase
		end
	end

	assign sel_code = code_reg[index_reg];
	assign sel_ts = ts_bcd_reg[index_reg];

	// Display registers follow the browse state one clock later
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			disp_state <= ST_FUNC_SEL;
			disp_index <= 4'h0;
			disp_digits <= 16'h0;
			disp_empty <= 1'b0;
			view_active <= 1'b0;
		end
		else
		begin
			disp_state <= state_reg;
			disp_index <= index_reg;
			view_active <= state_reg != ST_FUNC_SEL;
			disp_empty <= state_reg != ST_FUNC_SEL && !valid_reg[index_reg];
			if (state_reg == ST_FUNC_SEL || !valid_reg[index_reg])
				disp_digits <= 16'h0;
			else
			begin
				case (state_reg)
					ST_CODE: disp_digits <= {4'h0, sel_code};
					ST_TS_LOW: disp_digits <= sel_ts[15:0];
					ST_TS_MID: disp_digits <= sel_ts[31:16];
					ST_TS_HIGH: disp_digits <= {8'h00, sel_ts[39:32]};
					default: disp_digits <= 16'h0;
				endcase
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	AST_PUSH_NEWEST: assert property (store && !history_clear_function |=> valid_reg[0] && code_reg[0] == $past(alarm_code))
		else $error("new alarm not in newest slot");
	AST_OLDEST_DROPS: assert property (store && !history_clear_function |=> code_reg[9] == $past(code_reg[8]))
		else $error("history did not shift");
	AST_STAMP_LATCH: assert property (store && !history_clear_function |=> ts_bcd_reg[0] == $past(time_bcd_reg))
		else $error("time stamp not latched");
	AST_TIME_FROZEN: assert property (!power_on |=> time_bin_reg == $past(time_bin_reg))
		else $error("time advanced without power");
	AST_NO_WRAP: assert property (time_bin_reg != 32'h0 |=> time_bin_reg != 32'h0)
		else $error("time counter wrapped");
	AST_BCD_NO_WRAP: assert property (!carry[`TIME_DIGITS])
		else $error("decimal time copy wrapped");
	AST_DOWN_OLDER: assert property (state_reg != ST_FUNC_SEL && keys.down_press && !keys.step_long && !keys.step_short
		&& index_reg < 4'h9 |=> index_reg == $past(index_reg) + 4'h1)
		else $error("down key did not step older");
	AST_STEP_ORDER: assert property (state_reg == ST_CODE && keys.step_short && !keys.step_long
		|=> state_reg == ST_TS_LOW ##1 disp_digits == $past(ts_bcd_reg[index_reg][15:0], 1) || !valid_reg[index_reg])
		else $error("low stamp digits not shown");
	AST_BACK_TO_CODE: assert property (state_reg == ST_TS_HIGH && keys.step_short && !keys.step_long |=> state_reg == ST_CODE)
		else $error("no return to alarm code");
	AST_REPEAT_SKIP: assert property (alarm_valid && recent_hit != '0 && !history_clear_function
		|=> valid_reg == $past(valid_reg) && code_reg[0] == $past(code_reg[0]))
		else $error("repeat within the hour was stored");
	AST_EMPTY_DASH: assert property (state_reg != ST_FUNC_SEL && !valid_reg[index_reg] |=> disp_empty)
		else $error("empty slot not shown as dashes");
	AST_CLEAR_ONLY: assert property (history_clear_function |=> valid_reg == '0)
		else $error("clear left entries");
	AST_RESET_KEEPS: assert property (alarm_reset && !history_clear_function && !alarm_valid |=> valid_reg == $past(valid_reg))
		else $error("alarm reset touched history");
	AST_ENTER_VIEW: assert property (state_reg == ST_FUNC_SEL && history_view_function && keys.step_long
		|=> state_reg == ST_CODE && index_reg == 4'h0 ##1 view_active && disp_index == 4'h0)
		else $error("history view not entered at newest");
	AST_LEAVE_VIEW: assert property (state_reg != ST_FUNC_SEL && keys.step_long |=> state_reg == ST_FUNC_SEL ##1 !view_active)
		else $error("long press did not leave view");

	COV_STORE: cover property (store);
	COV_SUPPRESS: cover property (alarm_valid && recent_hit != '0);
	COV_FULL_WALK: cover property (state_reg == ST_TS_HIGH && keys.step_short);
	COV_OLDEST: cover property (state_reg != ST_FUNC_SEL && index_reg == 4'h9);
endmodule // alarm_history_recorder

// ===== tb/keypad_model.sv
// Operator keypad model: presses and releases the step, up and down keys
`timescale 1ns/100ps
module keypad_model #(
	parameter int LONG_CYCLES = 8
) (
	input wire logic clock,
	output logic key_step,
	output logic key_up,
	output logic key_down
);
	// Keys idle released
	initial
	begin
		{key_step, key_up, key_down} = 3'h0;
	end

	// Hold one key, change only after falling edges
	task automatic hold(input int which, input int cycles);
		@(negedge clock);
		case (which)
			0: key_step = 1'b1;
			1: key_up = 1'b1;
			default: key_down = 1'b1;
		endcase
		repeat (cycles) @(negedge clock);
		{key_step, key_up, key_down} = 3'h0;
	endtask

	// Short press released well before the long count
	task automatic short_step();
		hold(0, 2);
	endtask

	// Held LONG_CYCLES plus four cycles, a margin past the long count
	task automatic long_step();
		hold(0, LONG_CYCLES + 4);
	endtask

	task automatic up();
		hold(1, 2);
	endtask

	task automatic down();
		hold(2, 2);
	endtask
endmodule // keypad_model

// ===== tb/alarm_history_recorder_test.sv
// Self-checking bench for the alarm history recorder
`timescale 1ns/100ps
module alarm_history_recorder_test;
	import alarm_history_pkg::*;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic power_on = 1'b0;
	logic alarm_valid = 1'b0;
	logic [11:0] alarm_code = 12'h000;
	logic alarm_reset = 1'b0;
	logic history_view_function = 1'b0;
	logic history_clear_function = 1'b0;
	logic key_step, key_up, key_down;
	view_state_e disp_state;
	logic [3:0] disp_index;
	logic [15:0] disp_digits;
	logic disp_empty, view_active;
	int num_errors = 0;
	int cmp_count = 0;
	integer seed = 32'hbf8c;
	logic [24:0] notes[$];
	logic [11:0] codes[$];
	event sample_ev;

	always #20 clock = ~clock;

	// Short tick and long-press counts keep the run brief
	alarm_history_recorder #(.TICK_CYCLES(32'h2), .LONG_CYCLES(32'h8)) i_alarm_history_recorder (
		.clock(clock), .rstn(rstn), .power_on(power_on), .alarm_valid(alarm_valid),
		.alarm_code(alarm_code), .alarm_reset(alarm_reset),
		.history_view_function(history_view_function), .history_clear_function(history_clear_function),
		.key_step(key_step), .key_up(key_up), .key_down(key_down), .disp_state(disp_state),
		.disp_index(disp_index), .disp_digits(disp_digits), .disp_empty(disp_empty),
		.view_active(view_active));

	keypad_model #(.LONG_CYCLES(8)) keypad (.clock(clock), .key_step(key_step), .key_up(key_up),
		.key_down(key_down));

	task automatic check(input logic [24:0] seen, input logic [24:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Note the expected display, then let the watcher compare once settled
	task automatic expect_view(input view_state_e st, input logic [3:0] idx, input logic [15:0] dig,
		input logic emp, input logic act);
		notes.push_back({st, idx, dig, emp, act});
		repeat (8) @(negedge clock);
		->sample_ev;
		@(negedge clock);
	endtask

	// Watcher takes the oldest note whenever a result is due
	always @(sample_ev)
		check({disp_state, disp_index, disp_digits, disp_empty, view_active}, notes.pop_front());

	task automatic test_done();
		if (num_errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence, inputs change on falling edges
	initial
	begin
		repeat (16) @(negedge clock);
		rstn = 1'b1;
		expect_view(ST_FUNC_SEL, 4'h0, 16'h0000, 1'b0, 1'b0);
		// 4321 ticks of powered time, then freeze the counter
		power_on = 1'b1;
		repeat (2 * 4321) @(negedge clock);
		power_on = 1'b0;
		// Eleven distinct codes back to back; the first one falls out
		for (int i = 0; i < 11; i++)
		begin
			alarm_code = 12'(i * 12'h111 + ($random(seed) & 12'h00f));
			codes.push_front(alarm_code);
			alarm_valid = 1'b1;
			@(negedge clock);
		end
		alarm_valid = 1'b0;
		history_view_function = 1'b1;
		keypad.long_step();
		expect_view(ST_CODE, 4'h0, {4'h0, codes[0]}, 1'b0, 1'b1);
		for (int i = 1; i < 10; i++)
		begin
			keypad.down();
			expect_view(ST_CODE, 4'(i), {4'h0, codes[i]}, 1'b0, 1'b1);
		end
		keypad.down();
		expect_view(ST_CODE, 4'h9, {4'h0, codes[9]}, 1'b0, 1'b1);
		keypad.up();
		expect_view(ST_CODE, 4'h8, {4'h0, codes[8]}, 1'b0, 1'b1);
		keypad.short_step();
		expect_view(ST_TS_LOW, 4'h8, 16'h4321, 1'b0, 1'b1);
		keypad.short_step();
		expect_view(ST_TS_MID, 4'h8, 16'h0000, 1'b0, 1'b1);
		keypad.short_step();
		expect_view(ST_TS_HIGH, 4'h8, 16'h0000, 1'b0, 1'b1);
		keypad.short_step();
		expect_view(ST_CODE, 4'h8, {4'h0, codes[8]}, 1'b0, 1'b1);
		// Alarm reset while the view is open leaves the history alone
		alarm_reset = 1'b1;
		@(negedge clock);
		alarm_reset = 1'b0;
		keypad.long_step();
		expect_view(ST_FUNC_SEL, 4'h8, 16'h0000, 1'b0, 1'b0);
		keypad.long_step();
		expect_view(ST_CODE, 4'h0, {4'h0, codes[0]}, 1'b0, 1'b1);
		// Repeat at once is dropped
		alarm_code = codes[0];
		alarm_valid = 1'b1;
		@(negedge clock);
		alarm_valid = 1'b0;
		keypad.down();
		expect_view(ST_CODE, 4'h1, {4'h0, codes[1]}, 1'b0, 1'b1);
		// After 36001 ticks the same code is stored again
		power_on = 1'b1;
		repeat (2 * 36001) @(negedge clock);
		power_on = 1'b0;
		alarm_valid = 1'b1;
		@(negedge clock);
		alarm_valid = 1'b0;
		expect_view(ST_CODE, 4'h1, {4'h0, codes[0]}, 1'b0, 1'b1);
		keypad.up();
		keypad.short_step();
		expect_view(ST_TS_LOW, 4'h0, 16'h0322, 1'b0, 1'b1);
		keypad.short_step();
		expect_view(ST_TS_MID, 4'h0, 16'h0004, 1'b0, 1'b1);
		// Only the clear function and rstn empty the slots
		history_clear_function = 1'b1;
		@(negedge clock);
		history_clear_function = 1'b0;
		// Up at the newest entry is ignored, so the stamp view stays
		keypad.up();
		expect_view(ST_TS_MID, 4'h0, 16'h0000, 1'b1, 1'b1);
		test_done();
	end

	// Watchdog sized a little above the expected run
	initial
	begin
		repeat (90000) @(negedge clock);
		num_errors++;
		test_done();
	end
endmodule // alarm_history_recorder_test
